// [hw/clis_pkg.sv]
// constants and types of the comm loss and input supervisor
// Operation
// - any SPI communication fault switches the device into Fail mode
// - controller inverts the toggle bit each message; a repeated value is a fault
// - no valid message within 32 ms (select 0) or 128 ms (select 1) is a fault
// - frame bit count not a multiple of 16 is a fault
// - a fault sets the comm-loss flag, returned in the next SPI frame
// - comm-loss flag holds while in Fail mode whatever the traffic
// - comm-loss flag clears on the Fail-to-Normal transition
// - direct inputs, fallback, reset pin and reference clock are low-pass filtered
// - fallback and direct inputs deglitched on both edges, 200 us nominal
// - fallback held high past the deglitch time forces Fail mode
// - direct input held high past the deglitch time sets its filteredDirectInput bit
// - reset pin falling edge deglitched 10 us; rising edge acts at once
// - reference clock deglitched 2 us; too fast a clock reads as clock failure
// - clock frequency monitoring restarts at the reset pin rising edge
// - below 100 Hz reference clock, outputs follow the channel control signals
// - with a valid clock, outputs follow the programmed duty cycle generator
// - clock-fail diagnosis clears only after removal then a quick status read
package clis_pkg;

  localparam int unsigned MCLK_HZ      = 40_000_000;
  localparam int unsigned CH_NUM       = 5;
  localparam int unsigned DIR_NUM      = 4;
  localparam int unsigned WD_SHORT_MS  = 32;
  localparam int unsigned WD_LONG_MS   = 128;
  localparam int unsigned IN_DGL_US    = 200;
  localparam int unsigned CLK_DGL_NS   = 2000;
  localparam int unsigned RST_DGL_NS   = 10000;
  localparam int unsigned CLK_LOW_HZ   = 100;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * (MCLK_HZ / 1000);
  localparam int unsigned WD_LONG_CYC  = WD_LONG_MS * (MCLK_HZ / 1000);
  localparam int unsigned IN_DGL_CYC   = IN_DGL_US * (MCLK_HZ / 1_000_000);
  localparam int unsigned CLK_DGL_CYC  = CLK_DGL_NS / (1_000_000_000 / MCLK_HZ);
  localparam int unsigned RST_DGL_CYC  = RST_DGL_NS / (1_000_000_000 / MCLK_HZ);
  localparam int unsigned CLK_LOW_CYC  = MCLK_HZ / CLK_LOW_HZ;

  // frame word layout, MSB first on the wire
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned TOGGLE_POS   = 15;
  localparam int unsigned CMD_HI       = 14;
  localparam int unsigned CMD_LO       = 10;
  localparam logic [4:0]  QS_READ_CMD  = 5'h01;
  localparam int unsigned STAT_LOSS_POS = 15;
  localparam int unsigned STAT_CLKF_POS = 14;
  localparam int unsigned STAT_FAIL_POS = 13;

  // synchroniser bit positions
  localparam int unsigned SY_SCK  = 0;
  localparam int unsigned SY_CSN  = 1;
  localparam int unsigned SY_MOSI = 2;
  localparam int unsigned SY_FB   = 3;
  localparam int unsigned SY_IN0  = 4;
  localparam int unsigned SY_RST  = 8;
  localparam int unsigned SY_CLK  = 9;
  localparam int unsigned SY_NUM  = 10;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b01,
    MODE_FAIL   = 2'b10
  } clis_mode_t;

  typedef struct packed {
    logic sck;
    logic csN;
    logic mosi;
  } clis_spi_t;

endpackage

// [hw/comm_loss_input_supervisor.sv]
// SPI link watchdog, Fail mode control and input plausibility filters
`timescale 1ns/1ps
module comm_loss_input_supervisor
  import clis_pkg::*;
#(
  parameter int unsigned WD_SHORT_LIM = WD_SHORT_CYC,
  parameter int unsigned WD_LONG_LIM  = WD_LONG_CYC,
  parameter int unsigned IN_DGL_LIM   = IN_DGL_CYC,
  parameter int unsigned CLK_LOW_LIM  = CLK_LOW_CYC
)
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire clis_spi_t          spiIn,
  output logic                    spiMiso,
  output logic                    spiMisoOe,
  input  wire logic               timeoutSelect,
  input  wire logic               fallbackPin,
  input  wire logic [DIR_NUM-1:0] directChannelInput,
  input  wire logic               activeLowResetPin,
  input  wire logic               refClkPin,
  input  wire logic               exitFailRequest,
  input  wire logic [CH_NUM-1:0]  channelControlSignal,
  input  wire logic [CH_NUM-1:0]  pwmDrive,
  output logic                    failMode,
  output logic                    commLossFlag,
  output logic                    filteredFallbackRequest,
  output logic [DIR_NUM-1:0]      filteredDirectInput,
  output logic                    resetPinActive,
  output logic                    clkValid,
  output logic                    clkFailDiag,
  output logic [CH_NUM-1:0]       channelOut
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [SY_NUM-1:0]        s1;
    logic [SY_NUM-1:0]        s2;
    logic                     sckPrev;
    logic                     csnPrev;
    logic [DIR_NUM:0]         dglOut;
    logic [DIR_NUM:0][15:0]   dglCnt;
    logic                     rstFilt;
    logic [15:0]              rstCnt;
    logic                     clkFilt;
    logic [15:0]              clkCnt;
    logic                     clkFiltPrev;
    logic [18:0]              periodCnt;
    logic                     clkFailNow;
    logic                     clkDiag;
    logic                     failGone;
    logic [15:0]              rxShift;
    logic [3:0]               bitCnt;
    logic                     anyWord;
    logic                     toggleErr;
    logic                     prevToggle;
    logic                     havePrev;
    logic                     qsSeen;
    logic [15:0]              txShift;
    logic                     miso;
    logic [22:0]              wdCnt;
    clis_mode_t               mode;
    logic                     loss;
    logic [CH_NUM-1:0]        outQ;
  } clis_state_t;

  clis_state_t st_q;
  clis_state_t st_d;

  // ==========================================================================
  // helpers
  // symmetric deglitcher: output follows input once it differs for lim cycles
  function automatic logic [16:0] deglitch(input logic raw, input logic out,
                                           input logic [15:0] cnt, input logic [15:0] lim);
    logic [16:0] r;
    r = {out, 16'h0000};
    if (raw != out)
    begin
      if (cnt + 16'h0001 >= lim)
        r = {raw, 16'h0000};
      else
        r = {out, cnt + 16'h0001};
    end
    return r;
  endfunction

  logic [22:0] wdLimit;
  logic        sckRise;
  logic        sckFall;
  logic        frameStart;
  logic        frameEnd;
  logic        csActive;
  logic [15:0] rxWord;
  logic        lenErr;
  logic        goodFrame;
  logic        commFault;
  logic        wdExpired;
  logic        clkRise;
  logic [16:0] dr;

  always_comb
  begin
    wdLimit    = timeoutSelect ? 23'(WD_LONG_LIM - 1) : 23'(WD_SHORT_LIM - 1);
    csActive   = ~st_q.s2[SY_CSN];
    sckRise    = csActive & st_q.s2[SY_SCK] & ~st_q.sckPrev;
    sckFall    = csActive & ~st_q.s2[SY_SCK] & st_q.sckPrev;
    frameStart = ~st_q.s2[SY_CSN] & st_q.csnPrev;
    frameEnd   = st_q.s2[SY_CSN] & ~st_q.csnPrev;
    rxWord     = {st_q.rxShift[14:0], st_q.s2[SY_MOSI]};
    lenErr     = frameEnd & (st_q.bitCnt != 4'h0);
    goodFrame  = frameEnd & st_q.anyWord & ~lenErr & ~st_q.toggleErr;
    wdExpired  = (st_q.mode == MODE_NORMAL) & ~goodFrame & (st_q.wdCnt >= wdLimit);
    commFault  = st_q.rstFilt & ((frameEnd & (lenErr | st_q.toggleErr)) | wdExpired);
    clkRise    = st_q.clkFilt & ~st_q.clkFiltPrev;
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    dr   = 17'h00000;

    // two-flop synchronisers for the SPI, fallback, direct, reset and reference clock pins
    st_d.s1 = {refClkPin, activeLowResetPin, directChannelInput, fallbackPin,
               spiIn.mosi, spiIn.csN, spiIn.sck};
    st_d.s2 = st_q.s1;
    st_d.sckPrev = st_q.s2[SY_SCK];
    st_d.csnPrev = st_q.s2[SY_CSN];

    // fallback and direct inputs, both edges
    for (int i = 0; i <= DIR_NUM; i++)
    begin
      dr = deglitch(st_q.s2[SY_FB + i], st_q.dglOut[i], st_q.dglCnt[i],
                    16'(IN_DGL_LIM));
      st_d.dglOut[i] = dr[16];
      st_d.dglCnt[i] = dr[15:0];
    end

    // reset pin: falling edge filtered, rising edge immediate
    if (st_q.s2[SY_RST])
    begin
      st_d.rstFilt = 1'b1;
      st_d.rstCnt  = 16'h0000;
    end
    else if (st_q.rstFilt)
    begin
      if (st_q.rstCnt + 16'h0001 >= 16'(RST_DGL_CYC))
      begin
        st_d.rstFilt = 1'b0;
        st_d.rstCnt  = 16'h0000;
      end
      else
        st_d.rstCnt = st_q.rstCnt + 16'h0001;
    end

    // reference clock filter and low frequency check
    dr = deglitch(st_q.s2[SY_CLK], st_q.clkFilt, st_q.clkCnt, 16'(CLK_DGL_CYC));
    st_d.clkFilt     = dr[16];
    st_d.clkCnt      = dr[15:0];
    st_d.clkFiltPrev = st_q.clkFilt;
    if (~st_q.rstFilt)
    begin
      st_d.periodCnt  = 19'h00000;
      st_d.clkFailNow = 1'b0;
    end
    else if (clkRise)
    begin
      st_d.periodCnt  = 19'h00000;
      st_d.clkFailNow = 1'b0;
    end
    else if (st_q.periodCnt >= 19'(CLK_LOW_LIM - 1))
      st_d.clkFailNow = 1'b1;
    else
      st_d.periodCnt = st_q.periodCnt + 19'h00001;

    // clock fail diagnosis: removal first, then quick status read
    if (st_q.clkFailNow)
    begin
      st_d.clkDiag  = 1'b1;
      st_d.failGone = 1'b0;
    end
    else if (st_q.clkDiag)
    begin
      if (st_q.failGone & goodFrame & st_q.qsSeen)
      begin
        st_d.clkDiag  = 1'b0;
        st_d.failGone = 1'b0;
      end
      else
        st_d.failGone = 1'b1;
    end

    // SPI receive and transmit
    if (frameStart)
    begin
      st_d.bitCnt    = 4'h0;
      st_d.anyWord   = 1'b0;
      st_d.toggleErr = 1'b0;
      st_d.qsSeen    = 1'b0;
      st_d.txShift   = 16'h0000;
      st_d.txShift[STAT_LOSS_POS] = st_q.loss;
      st_d.txShift[STAT_CLKF_POS] = st_q.clkDiag;
      st_d.txShift[STAT_FAIL_POS] = (st_q.mode == MODE_FAIL);
      st_d.miso = st_q.loss;
    end
    if (sckRise)
    begin
      st_d.rxShift = rxWord;
      st_d.bitCnt  = st_q.bitCnt + 4'h1;
      if (st_q.bitCnt == 4'(WORD_BITS - 1))
      begin
        st_d.anyWord    = 1'b1;
        st_d.havePrev   = 1'b1;
        st_d.prevToggle = rxWord[TOGGLE_POS];
        if (st_q.havePrev & (rxWord[TOGGLE_POS] == st_q.prevToggle))
          st_d.toggleErr = 1'b1;
        if (rxWord[CMD_HI:CMD_LO] == QS_READ_CMD)
          st_d.qsSeen = 1'b1;
      end
    end
    if (sckFall)
    begin
      st_d.txShift = {st_q.txShift[14:0], 1'b0};
      st_d.miso    = st_q.txShift[14];
    end

    // watchdog timer, runs in Normal mode only
    if (goodFrame | (st_q.mode == MODE_FAIL) | wdExpired)
      st_d.wdCnt = 23'h000000;
    else
      st_d.wdCnt = st_q.wdCnt + 23'h000001;

    // operating mode and comm-loss flag
    unique case (st_q.mode)
      MODE_NORMAL:
      begin
        if (commFault | st_q.dglOut[0])
          st_d.mode = MODE_FAIL;
        if (commFault)
          st_d.loss = 1'b1;
      end
      MODE_FAIL:
      begin
        if (commFault)
          st_d.loss = 1'b1;
        else if (exitFailRequest & ~st_q.dglOut[0])
        begin
          st_d.mode = MODE_NORMAL;
          st_d.loss = 1'b0;
        end
      end
    endcase

    // reset pin held low: link supervision restarts from scratch
    if (~st_q.rstFilt)
    begin
      st_d.mode     = MODE_NORMAL;
      st_d.loss     = 1'b0;
      st_d.wdCnt    = 23'h000000;
      st_d.havePrev = 1'b0;
    end

    // output source selection
    for (int c = 0; c < CH_NUM; c++)
    begin
      if (st_q.clkFailNow)
        st_d.outQ[c] = channelControlSignal[c];
      else
        st_d.outQ[c] = pwmDrive[c];
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q      <= '0;
      st_q.s1   <= 10'h302;
      st_q.s2   <= 10'h302;
      st_q.csnPrev <= 1'b1;
      st_q.rstFilt <= 1'b1;
      st_q.mode <= MODE_NORMAL;
    end
    else
      st_q <= st_d;
  end

  // ==========================================================================
  // outputs
  assign spiMiso                 = st_q.miso;
  assign spiMisoOe               = csActive;
  assign failMode                = (st_q.mode == MODE_FAIL);
  assign commLossFlag            = st_q.loss;
  assign filteredFallbackRequest = st_q.dglOut[0];
  assign filteredDirectInput     = st_q.dglOut[DIR_NUM:1];
  assign resetPinActive          = ~st_q.rstFilt;
  assign clkValid                = ~st_q.clkFailNow;
  assign clkFailDiag             = st_q.clkDiag;
  assign channelOut              = st_q.outQ;

endmodule

// [tb/clis_mcu_model.sv]
// controller side model: SPI master driving the supervisor link
`timescale 1ns/1ps
module clis_mcu_model
  import clis_pkg::*;
(
  input  wire logic mclk,
  output clis_spi_t spi,
  input  wire logic miso
);
  // sck idles low between frames
  initial spi = '{sck: 1'b0, csN: 1'b1, mosi: 1'b0};

  // n bits of d, msb first, mode 0; toggle content comes from the caller
  task automatic xfer(input logic [31:0] d, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(negedge mclk);
    spi.csN = 1'b0;
    // 200 ns link clock: 4 mclk per half period, data changes with the falling edge
    for (int i = 0; i < n; i++)
    begin
      spi.mosi = d[31-i];
      repeat (4) @(negedge mclk);
      spi.sck = 1'b1;
      if (i < 16)
        r[15-i] = miso;
      repeat (4) @(negedge mclk);
      spi.sck = 1'b0;
    end
    repeat (4) @(negedge mclk);
    spi.csN = 1'b1;
    // released data line shows the inverse of its last value
    spi.mosi = ~spi.mosi;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// [tb/clis_sva.sv]
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
module clis_sva
  import clis_pkg::*;
#(
  parameter int unsigned IN_DGL_LIM = IN_DGL_CYC
)
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               fallbackPin,
  input wire logic [DIR_NUM-1:0] directChannelInput,
  input wire logic               activeLowResetPin,
  input wire logic [CH_NUM-1:0]  channelControlSignal,
  input wire logic [CH_NUM-1:0]  pwmDrive,
  input wire logic               failMode,
  input wire logic               commLossFlag,
  input wire logic               filteredFallbackRequest,
  input wire logic [DIR_NUM-1:0] filteredDirectInput,
  input wire logic               resetPinActive,
  input wire logic               clkValid,
  input wire logic               clkFailDiag,
  input wire logic [CH_NUM-1:0]  channelOut
);
  // ==========================================================
  // run lengths of raw pin levels, saturating
  logic [15:0] fbHi_q, fbLo_q, inHi_q, rstLo_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      {fbHi_q, fbLo_q, inHi_q, rstLo_q} <= 64'h0;
    else
    begin
      fbHi_q  <= fallbackPin ? fbHi_q + {15'h0, ~&fbHi_q} : 16'h0;
      fbLo_q  <= !fallbackPin ? fbLo_q + {15'h0, ~&fbLo_q} : 16'h0;
      inHi_q  <= directChannelInput[0] ? inHi_q + {15'h0, ~&inHi_q} : 16'h0;
      rstLo_q <= !activeLowResetPin ? rstLo_q + {15'h0, ~&rstLo_q} : 16'h0;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence failExit;
    failMode ##1 !failMode;
  endsequence
  exit_clears_a: assert property (failExit |-> !commLossFlag) else $error("flag kept after exit");
  flag_in_fail_a: assert property (commLossFlag |-> failMode) else $error("flag outside fail");
  flag_holds_a: assert property (commLossFlag && failMode |=> commLossFlag || !failMode) else $error("flag lost");
  fb_fail_a: assert property (filteredFallbackRequest && !resetPinActive |=> failMode) else $error("no fail");
  fb_rise_a: assert property ($rose(filteredFallbackRequest) |-> fbHi_q >= IN_DGL_LIM) else $error("fb rise");
  fb_fall_a: assert property ($fell(filteredFallbackRequest) |-> fbLo_q >= IN_DGL_LIM) else $error("fb fall");
  dir_rise_a: assert property ($rose(filteredDirectInput[0]) |-> inHi_q >= IN_DGL_LIM) else $error("dir rise");
  rst_filter_a: assert property ($rose(resetPinActive) |-> rstLo_q >= RST_DGL_CYC) else $error("rst fall");
  out_mux_a: assert property (1'b1 |=> channelOut == ($past(clkValid) ? $past(pwmDrive)
    : $past(channelControlSignal))) else $error("channel output source");
  diag_set_a: assert property (!clkValid |=> clkFailDiag) else $error("clock fail not diagnosed");
  diag_clear_a: assert property ($fell(clkFailDiag) |-> clkValid && $past(clkValid)) else $error("early clear");
endmodule

bind comm_loss_input_supervisor clis_sva #(.IN_DGL_LIM(IN_DGL_LIM)) chk_u (.*);

// [tb/tb.sv]
// self-checking bench of the comm loss and input supervisor
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end
module tb
  import clis_pkg::*;
;
  // short timeout must exceed a 32-bit frame plus its lead-in
  localparam int unsigned DGL = 20, WDS = 300, WDL = 1200, CLKL = 2000;
  logic               mclk, rst_n, tSel, fbPin, rstPin, refPin, exitReq, tg;
  logic               miso, misoOe, failM, lossF, fbF, rstAct, clkV, clkD;
  logic [1:0]         refMode = 2'd0;
  logic [15:0]        rx;
  logic [DIR_NUM-1:0] dirIn, dirF;
  logic [CH_NUM-1:0]  chCtl, pwm, chOut;
  clis_spi_t          spi;
  int                 miscompares = 0;
  int                 nTests = 0;

  comm_loss_input_supervisor #(.WD_SHORT_LIM(WDS), .WD_LONG_LIM(WDL), .IN_DGL_LIM(DGL), .CLK_LOW_LIM(CLKL)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .spiIn(spi), .spiMiso(miso), .spiMisoOe(misoOe), .timeoutSelect(tSel),
    .fallbackPin(fbPin), .directChannelInput(dirIn), .activeLowResetPin(rstPin), .refClkPin(refPin),
    .exitFailRequest(exitReq), .channelControlSignal(chCtl), .pwmDrive(pwm), .failMode(failM),
    .commLossFlag(lossF), .filteredFallbackRequest(fbF), .filteredDirectInput(dirF),
    .resetPinActive(rstAct), .clkValid(clkV), .clkFailDiag(clkD), .channelOut(chOut));
  clis_mcu_model mcu_u (.mclk(mclk), .spi(spi), .miso(miso));

  // ==========================================================
  // access tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // v = {fallback, direct[3:0], reset pin}
  task automatic stim(input logic [5:0] v, input int n);
    {fbPin, dirIn, rstPin} = v;
    cyc(n);
  endtask
  // rep keeps the toggle bit to provoke a fault
  task automatic frame(input logic [4:0] cmd, input int n, input logic rep);
    if (!rep)
      tg = ~tg;
    mcu_u.xfer({tg, cmd, 10'h000, ~tg, cmd, 10'h000}, n, rx);
    if (n == 32)
      tg = ~tg;
  endtask
  task automatic leave();
    exitReq = 1'b1;
    cyc(1);
    exitReq = 1'b0;
    cyc(1);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // clocks, watchdog and test sequence
  always #(refMode == 2'd1 ? 100 : 5000) if (refMode != 2'd0) refPin = ~refPin;
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    #1_000_000;
    miscompares++;
    conclude();
  end
  initial
  begin
    {rst_n, tSel, exitReq, tg, refPin} = 5'h08;
    {chCtl, pwm} = 10'h2AA;
    refMode = 2'd0;
    stim(6'h01, 4);
    rst_n = 1'b1;
    cyc(1);
    `CHK({failM, lossF, clkV, misoOe}, 4'b0010)
    repeat (3) frame(5'h00, 16, 1'b0);
    `CHK({failM, rx[15], rx[13], misoOe}, 4'b0000)
    frame(5'h00, 16, 1'b1);
    `CHK({failM, lossF}, 2'b11)
    frame(5'h00, 16, 1'b0);
    `CHK({rx[15], rx[13]}, 2'b11)
    frame(5'h00, 16, 1'b1);
    `CHK(lossF, 1'b1)
    leave();
    `CHK({failM, lossF}, 2'b00)
    frame(5'h00, 17, 1'b0);
    `CHK(failM, 1'b1)
    leave();
    frame(5'h00, 32, 1'b0);
    `CHK(failM, 1'b0)
    done("link faults");
    tSel = 1'b0;
    cyc(WDS - 40);
    `CHK(failM, 1'b0)
    cyc(60);
    `CHK(failM, 1'b1)
    tSel = 1'b1;
    leave();
    cyc(WDL - 40);
    `CHK(failM, 1'b0)
    cyc(60);
    `CHK(failM, 1'b1)
    leave();
    done("timeout");
    stim(6'h21, DGL - 8);
    stim(6'h0B, DGL - 8);
    stim(6'h01, DGL + 10);
    `CHK({fbF, dirF, failM}, 6'h00)
    stim(6'h21, DGL + 10);
    `CHK({fbF, failM}, 2'b11)
    stim(6'h13, DGL - 10);
    `CHK(fbF, 1'b1)
    stim(6'h13, 20);
    `CHK({fbF, dirF}, 5'h09)
    stim(6'h01, DGL - 10);
    `CHK(dirF, 4'h9)
    stim(6'h01, 20);
    `CHK(dirF, 4'h0)
    leave();
    `CHK(failM, 1'b0)
    done("filters");
    `CHK({clkV, clkD, chOut}, {2'b01, chCtl})
    frame(5'h00, 16, 1'b1);
    refMode = 2'd1;
    cyc(CLKL + 200);
    `CHK(clkV, 1'b0)
    refMode = 2'd2;
    cyc(1000);
    `CHK({clkV, clkD, chOut}, {2'b11, pwm})
    leave();
    frame(5'h00, 16, 1'b0);
    `CHK(clkD, 1'b1)
    frame(QS_READ_CMD, 16, 1'b0);
    `CHK(clkD, 1'b0)
    done("clock");
    frame(5'h00, 16, 1'b1);
    stim(6'h00, 200);
    stim(6'h01, 10);
    `CHK({rstAct, failM}, 2'b01)
    refMode = 2'd0;
    stim(6'h00, 450);
    `CHK({rstAct, failM, lossF}, 3'b100)
    stim(6'h01, 5);
    `CHK(rstAct, 1'b0)
    cyc(CLKL - 100);
    `CHK(clkV, 1'b1)
    cyc(200);
    `CHK(clkV, 1'b0)
    done("reset pin");
    conclude();
  end
endmodule
